// [mixer_hp_regs_defines.vh]
/*
 * Constants for the output mixer path gain and headphone volume
 * register bank: register offsets, field positions, reset values and
 * the path gain decode. Included by the register bank and by the
 * headphone channel module; holds definitions only.
 */
// Notes on behaviour
// - Path gain code 0 disconnects; 1 is -12dB, 2 is -9dB, 7 is +6dB.
// - Left mixer register bits 3:1 hold left preamp gain, reset 0.
// - Left mixer register bits 7:5 hold right preamp gain, reset 0.
// - Left mixer register bits 11:9 hold left aux gain, reset 0.
// - Right mixer register bits 3:1 hold left preamp gain, reset 0.
// - Right mixer register bits 7:5 hold right preamp gain, reset 0.
// - Right mixer register bits 15:13 hold right aux gain, reset 0.
// - Output mixer gains are own storage, record mixer gains untouched.
// - Headphone volume bit 14 mutes that channel, reset 0.
// - Bit 13 set defers gain change to a zero crossing, reset 0.
// - Written volumes stay pending until update bit 8 is written one.
// - Six-bit volume in bits 7:2, reset code 0x39 means 0dB.
// - Output control bit 0 enables common return ground feedback.
// - Headphone enables live in power register and volume bit 15.
`ifndef MIXER_HP_REGS_DEFINES_VH
`define MIXER_HP_REGS_DEFINES_VH

// ============================================================
// Register offsets
`define ADDR_W               8
`define DATA_W               16
`define ADDR_POWER_MGMT      8'h0A
`define ADDR_OUTPUT_CONTROL  8'h4C
`define ADDR_LEFT_MIX_GAIN   8'h60
`define ADDR_RIGHT_MIX_GAIN  8'h61
`define ADDR_HP_LEFT_VOL     8'h68
`define ADDR_HP_RIGHT_VOL    8'h69

// ============================================================
// Mixer path gain fields
`define PATH_GAIN_W          3
`define PATH_GAIN_RESET      3'h0
`define PATH_OFF_CODE        3'h0
`define LPRE_GAIN_LSB        1
`define RPRE_GAIN_LSB        5
`define LAUX_GAIN_LSB        9
`define RAUX_GAIN_LSB        13
`define PATH_DB_W            5
`define PATH_DB_STEP         5'h03
`define PATH_DB_OFFSET       5'h0F
`define PATH_DB_OFF          5'h00
`define LIVE_RESET           6'h00

// ============================================================
// Headphone volume fields
`define HP_GAIN_W            6
`define HP_GAIN_LSB          2
`define HP_GAIN_RESET        6'h39
`define HP_COMMIT_BIT        8
`define HP_ZC_BIT            13
`define HP_SILENCE_BIT       14
`define HP_ON_BIT            15

// ============================================================
// Power management and output control fields
`define PWR_LEFT_ON_BIT      0
`define PWR_RIGHT_ON_BIT     1
`define FEEDBACK_BIT         0
`define BIT_RESET            1'h0
`define READ_ZERO            16'h0000

`endif

// [hp_volume_channel.v]
/*
 * One headphone channel volume stage: pending gain, applied gain and
 * the zero-cross deferral of a committed change.
 * Assumes load and commit come from the register bank in one cycle,
 * and that zero_cross is a one-cycle pulse synchronous to ref_clk.
 */
`timescale 1ns/1ns
`include "mixer_hp_regs_defines.vh"

module hp_volume_channel (
    input  wire                   ref_clk,
    input  wire                   reset,
    input  wire                   load,
    input  wire [`HP_GAIN_W-1:0]  load_gain,
    input  wire                   commit,
    input  wire                   zc_en,
    input  wire                   zero_cross,
    output reg  [`HP_GAIN_W-1:0]  pending_gain,
    output reg  [`HP_GAIN_W-1:0]  applied_gain,
    output reg                    waiting
);

    wire [`HP_GAIN_W-1:0] next_pending;

    // A write that carries the update bit commits its own new value
    assign next_pending = load ? load_gain : pending_gain;

    always @(posedge ref_clk) begin
        if (reset) begin
            pending_gain <= `HP_GAIN_RESET;
            applied_gain <= `HP_GAIN_RESET;
            waiting      <= `BIT_RESET;
        end else begin
            pending_gain <= next_pending;
            if (commit && !zc_en) begin
                applied_gain <= next_pending;
                waiting      <= 1'b0;
            end else if (commit) begin
                waiting      <= 1'b1;
            end else if (waiting && (zero_cross || !zc_en)) begin
                // Dropping zc while armed releases the change at once
                applied_gain <= pending_gain;
                waiting      <= 1'b0;
            end
        end
    end

endmodule

// [output_mixer_gain_headphone_volume_regs.v]
/*
 * Register bank for the output mixer path gains, the first headphone
 * pair volume, mute, zero-cross and enable bits, and the common return
 * ground feedback enable.
 * Assumes a plain register port on ref_clk: one-cycle write or read
 * strobes, never both at once, read data valid the cycle after a read.
 * Zero-cross pulses come from the analogue side, already synchronous.
 */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "mixer_hp_regs_defines.vh"

module output_mixer_gain_headphone_volume_regs (
    input  wire                       ref_clk,
    input  wire                       reset,
    input  wire [`ADDR_W-1:0]         reg_addr,
    input  wire [`DATA_W-1:0]         reg_wdata,
    input  wire                       reg_wr,
    input  wire                       reg_rd,
    output reg  [`DATA_W-1:0]         reg_rdata,
    input  wire                       left_zero_cross,
    input  wire                       right_zero_cross,
    output reg  [`PATH_GAIN_W-1:0]    lpre_to_lmix_gain,
    output reg  [`PATH_GAIN_W-1:0]    rpre_to_lmix_gain,
    output reg  [`PATH_GAIN_W-1:0]    laux_to_lmix_gain,
    output reg  [`PATH_GAIN_W-1:0]    lpre_to_rmix_gain,
    output reg  [`PATH_GAIN_W-1:0]    rpre_to_rmix_gain,
    output reg  [`PATH_GAIN_W-1:0]    raux_to_rmix_gain,
    output reg  [`PATH_DB_W-1:0]      lpre_to_lmix_db,
    output reg  [`PATH_DB_W-1:0]      rpre_to_lmix_db,
    output reg  [`PATH_DB_W-1:0]      laux_to_lmix_db,
    output reg  [`PATH_DB_W-1:0]      lpre_to_rmix_db,
    output reg  [`PATH_DB_W-1:0]      rpre_to_rmix_db,
    output reg  [`PATH_DB_W-1:0]      raux_to_rmix_db,
    output reg  [5:0]                 mix_path_live,
    output wire [`HP_GAIN_W-1:0]      hp_left_gain,
    output wire [`HP_GAIN_W-1:0]      hp_right_gain,
    output wire                       hp_left_waiting,
    output wire                       hp_right_waiting,
    output reg                        hp_left_silence,
    output reg                        hp_right_silence,
    output reg                        hp_left_zero_cross,
    output reg                        hp_right_zero_cross,
    output reg                        hp_left_on,
    output reg                        hp_right_on,
    output reg                        hp_ground_feedback_en
);

    // ============================================================
    // Address decode
    wire wr_pwr   = reg_wr && (reg_addr == `ADDR_POWER_MGMT);
    wire wr_outc  = reg_wr && (reg_addr == `ADDR_OUTPUT_CONTROL);
    wire wr_lmix  = reg_wr && (reg_addr == `ADDR_LEFT_MIX_GAIN);
    wire wr_rmix  = reg_wr && (reg_addr == `ADDR_RIGHT_MIX_GAIN);
    wire wr_hpl   = reg_wr && (reg_addr == `ADDR_HP_LEFT_VOL);
    wire wr_hpr   = reg_wr && (reg_addr == `ADDR_HP_RIGHT_VOL);

    // Update bit is a strobe, never stored, so it always reads zero
    wire commit_hp = (wr_hpl || wr_hpr)
                     && reg_wdata[`HP_COMMIT_BIT];

    // Zero-cross choice seen by a commit includes the same write's value
    wire zc_left_next  = wr_hpl ? reg_wdata[`HP_ZC_BIT]
                                : hp_left_zero_cross;
    wire zc_right_next = wr_hpr ? reg_wdata[`HP_ZC_BIT]
                                : hp_right_zero_cross;

    wire [`HP_GAIN_W-1:0] pend_left;
    wire [`HP_GAIN_W-1:0] pend_right;

    // ============================================================
    // Path gain decode: 3dB steps from -12dB at code 1
    function [`PATH_DB_W-1:0] path_db;
        input [`PATH_GAIN_W-1:0] code;
        begin
            if (code == `PATH_OFF_CODE) begin
                path_db = `PATH_DB_OFF;
            end else begin
                path_db = {2'h0, code} * `PATH_DB_STEP
                          - `PATH_DB_OFFSET;
            end
        end
    endfunction

    // ============================================================
    // Mixer path gain storage, separate from any record mixer gain
    always @(posedge ref_clk) begin
        if (reset) begin
            lpre_to_lmix_gain <= `PATH_GAIN_RESET;
            rpre_to_lmix_gain <= `PATH_GAIN_RESET;
            laux_to_lmix_gain <= `PATH_GAIN_RESET;
            lpre_to_rmix_gain <= `PATH_GAIN_RESET;
            rpre_to_rmix_gain <= `PATH_GAIN_RESET;
            raux_to_rmix_gain <= `PATH_GAIN_RESET;
        end else begin
            if (wr_lmix) begin
                lpre_to_lmix_gain <= reg_wdata[`LPRE_GAIN_LSB +:
                                               `PATH_GAIN_W];
                rpre_to_lmix_gain <= reg_wdata[`RPRE_GAIN_LSB +:
                                               `PATH_GAIN_W];
                laux_to_lmix_gain <= reg_wdata[`LAUX_GAIN_LSB +:
                                               `PATH_GAIN_W];
            end
            if (wr_rmix) begin
                lpre_to_rmix_gain <= reg_wdata[`LPRE_GAIN_LSB +:
                                               `PATH_GAIN_W];
                rpre_to_rmix_gain <= reg_wdata[`RPRE_GAIN_LSB +:
                                               `PATH_GAIN_W];
                raux_to_rmix_gain <= reg_wdata[`RAUX_GAIN_LSB +:
                                               `PATH_GAIN_W];
            end
        end
    end

    // ============================================================
    // Decoded path gain, registered: lags the field by one cycle
    always @(posedge ref_clk) begin
        if (reset) begin
            lpre_to_lmix_db <= `PATH_DB_OFF;
            rpre_to_lmix_db <= `PATH_DB_OFF;
            laux_to_lmix_db <= `PATH_DB_OFF;
            lpre_to_rmix_db <= `PATH_DB_OFF;
            rpre_to_rmix_db <= `PATH_DB_OFF;
            raux_to_rmix_db <= `PATH_DB_OFF;
            mix_path_live   <= `LIVE_RESET;
        end else begin
            lpre_to_lmix_db <= path_db(lpre_to_lmix_gain);
            rpre_to_lmix_db <= path_db(rpre_to_lmix_gain);
            laux_to_lmix_db <= path_db(laux_to_lmix_gain);
            lpre_to_rmix_db <= path_db(lpre_to_rmix_gain);
            rpre_to_rmix_db <= path_db(rpre_to_rmix_gain);
            raux_to_rmix_db <= path_db(raux_to_rmix_gain);
            mix_path_live   <= {
                raux_to_rmix_gain != `PATH_OFF_CODE,
                rpre_to_rmix_gain != `PATH_OFF_CODE,
                lpre_to_rmix_gain != `PATH_OFF_CODE,
                laux_to_lmix_gain != `PATH_OFF_CODE,
                rpre_to_lmix_gain != `PATH_OFF_CODE,
                lpre_to_lmix_gain != `PATH_OFF_CODE
            };
        end
    end

    // ============================================================
    // Headphone control bits
    always @(posedge ref_clk) begin
        if (reset) begin
            hp_left_silence       <= `BIT_RESET;
            hp_right_silence      <= `BIT_RESET;
            hp_left_zero_cross    <= `BIT_RESET;
            hp_right_zero_cross   <= `BIT_RESET;
            hp_left_on            <= `BIT_RESET;
            hp_right_on           <= `BIT_RESET;
            hp_ground_feedback_en <= `BIT_RESET;
        end else begin
            if (wr_hpl) begin
                hp_left_silence    <= reg_wdata[`HP_SILENCE_BIT];
                hp_left_zero_cross <= reg_wdata[`HP_ZC_BIT];
                hp_left_on         <= reg_wdata[`HP_ON_BIT];
            end
            if (wr_hpr) begin
                hp_right_silence    <= reg_wdata[`HP_SILENCE_BIT];
                hp_right_zero_cross <= reg_wdata[`HP_ZC_BIT];
                hp_right_on         <= reg_wdata[`HP_ON_BIT];
            end
            // Second window onto the same enable flops
            if (wr_pwr) begin
                hp_left_on  <= reg_wdata[`PWR_LEFT_ON_BIT];
                hp_right_on <= reg_wdata[`PWR_RIGHT_ON_BIT];
            end
            if (wr_outc) begin
                hp_ground_feedback_en <= reg_wdata[`FEEDBACK_BIT];
            end
        end
    end

    // ============================================================
    // Volume channels share one commit so both sides move together when zero-cross is off on both
    hp_volume_channel left_channel (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .load         (wr_hpl),
        .load_gain    (reg_wdata[`HP_GAIN_LSB +: `HP_GAIN_W]),
        .commit       (commit_hp),
        .zc_en        (zc_left_next),
        .zero_cross   (left_zero_cross),
        .pending_gain (pend_left),
        .applied_gain (hp_left_gain),
        .waiting      (hp_left_waiting)
    );

    hp_volume_channel right_channel (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .load         (wr_hpr),
        .load_gain    (reg_wdata[`HP_GAIN_LSB +: `HP_GAIN_W]),
        .commit       (commit_hp),
        .zc_en        (zc_right_next),
        .zero_cross   (right_zero_cross),
        .pending_gain (pend_right),
        .applied_gain (hp_right_gain),
        .waiting      (hp_right_waiting)
    );

    // ============================================================
    // Read path: undefined bits and unmapped offsets read zero
    reg [`DATA_W-1:0] rd_mux;

    always @* begin
        rd_mux = `READ_ZERO;
        case (reg_addr)
            `ADDR_POWER_MGMT: begin
                rd_mux[`PWR_LEFT_ON_BIT]  = hp_left_on;
                rd_mux[`PWR_RIGHT_ON_BIT] = hp_right_on;
            end
            `ADDR_OUTPUT_CONTROL: begin
                rd_mux[`FEEDBACK_BIT] = hp_ground_feedback_en;
            end
            `ADDR_LEFT_MIX_GAIN: begin
                rd_mux[`LPRE_GAIN_LSB +: `PATH_GAIN_W] = lpre_to_lmix_gain;
                rd_mux[`RPRE_GAIN_LSB +: `PATH_GAIN_W] = rpre_to_lmix_gain;
                rd_mux[`LAUX_GAIN_LSB +: `PATH_GAIN_W] = laux_to_lmix_gain;
            end
            `ADDR_RIGHT_MIX_GAIN: begin
                rd_mux[`LPRE_GAIN_LSB +: `PATH_GAIN_W] = lpre_to_rmix_gain;
                rd_mux[`RPRE_GAIN_LSB +: `PATH_GAIN_W] = rpre_to_rmix_gain;
                rd_mux[`RAUX_GAIN_LSB +: `PATH_GAIN_W] = raux_to_rmix_gain;
            end
            `ADDR_HP_LEFT_VOL: begin
                rd_mux[`HP_ON_BIT]      = hp_left_on;
                rd_mux[`HP_SILENCE_BIT] = hp_left_silence;
                rd_mux[`HP_ZC_BIT]      = hp_left_zero_cross;
                // Software sees what it wrote, not what is applied yet
                rd_mux[`HP_GAIN_LSB +: `HP_GAIN_W] = pend_left;
            end
            `ADDR_HP_RIGHT_VOL: begin
                rd_mux[`HP_ON_BIT]      = hp_right_on;
                rd_mux[`HP_SILENCE_BIT] = hp_right_silence;
                rd_mux[`HP_ZC_BIT]      = hp_right_zero_cross;
                rd_mux[`HP_GAIN_LSB +: `HP_GAIN_W] = pend_right;
            end
            default: begin
                rd_mux = `READ_ZERO;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= `READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= `READ_ZERO;
        end
    end

endmodule

// [mixer_hp_checker.sv]
/*
 * Concurrent checks on the output mixer gain and headphone volume
 * register bank, watching only its top-level ports.
 * Assumes it is bound to the bank from the testbench top file.
 */
`timescale 1ns/1ns
`include "mixer_hp_regs_defines.vh"

module mixer_hp_checker (
    input wire                    ref_clk,
    input wire                    reset,
    input wire [`ADDR_W-1:0]      reg_addr,
    input wire [`DATA_W-1:0]      reg_wdata,
    input wire                    reg_wr,
    input wire                    reg_rd,
    input wire [`DATA_W-1:0]      reg_rdata,
    input wire                    left_zero_cross,
    input wire [`PATH_GAIN_W-1:0] lpre_to_lmix_gain,
    input wire [`PATH_GAIN_W-1:0] raux_to_rmix_gain,
    input wire [`PATH_DB_W-1:0]   lpre_to_lmix_db,
    input wire [5:0]              mix_path_live,
    input wire [`HP_GAIN_W-1:0]   hp_left_gain,
    input wire                    hp_left_waiting,
    input wire                    hp_ground_feedback_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ========================================================
    // Named steps of a left volume commit
    sequence left_commit_now;
        reg_wr && reg_addr == 8'h68 && reg_wdata[8] && !reg_wdata[13];
    endsequence
    sequence left_commit_later;
        reg_wr && reg_addr == 8'h68 && reg_wdata[8] && reg_wdata[13];
    endsequence

    // ========================================================
    // Assertions
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_db_plus6: assert property (lpre_to_lmix_gain == 3'h7 |=>
        lpre_to_lmix_db == 5'h06) else $error("code 7 not +6 dB");
    a_db_minus12: assert property (lpre_to_lmix_gain == 3'h1 |=>
        lpre_to_lmix_db == 5'h14) else $error("code 1 not -12 dB");
    a_path_off: assert property (lpre_to_lmix_gain == 3'h0 |=>
        lpre_to_lmix_db == 5'h00 && !mix_path_live[0])
        else $error("code 0 path not off");
    a_lpre_write: assert property (reg_wr && reg_addr == 8'h60 |=>
        lpre_to_lmix_gain == $past(reg_wdata[3:1]))
        else $error("left preamp gain field wrong");
    a_raux_hold: assert property (!(reg_wr && reg_addr == 8'h61) |=>
        $stable(raux_to_rmix_gain)) else $error("right aux gain moved");
    a_vol_pending: assert property (!(reg_wr && reg_wdata[8] &&
        (reg_addr == 8'h68 || reg_addr == 8'h69)) && !hp_left_waiting
        |=> $stable(hp_left_gain)) else $error("volume applied early");
    a_commit_now: assert property (left_commit_now |=>
        hp_left_gain == $past(reg_wdata[7:2]) && !hp_left_waiting)
        else $error("commit not applied at once");
    a_zc_defer: assert property (left_commit_later |=>
        hp_left_waiting) else $error("zero-cross commit not deferred");
    a_zc_apply: assert property (hp_left_waiting && left_zero_cross &&
        !reg_wr |=> !hp_left_waiting) else $error("zero cross ignored");
    a_feedback_en: assert property (reg_wr && reg_addr == 8'h4C |=>
        hp_ground_feedback_en == $past(reg_wdata[0]))
        else $error("feedback enable wrong");
endmodule

// [output_mixer_gain_headphone_volume_regs_tb.sv]
/*
 * Self-checking testbench for the mixer gain and headphone volume bank.
 * Assumes the register port of the bank and its defines header.
 */
`timescale 1ns/1ns
`include "mixer_hp_regs_defines.vh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module output_mixer_gain_headphone_volume_regs_tb;
    reg         ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         left_zero_cross = 1'b0, right_zero_cross = 1'b0;
    wire [15:0] reg_rdata;
    wire [2:0]  g0, g1, g2, g3, g4, g5;
    wire [4:0]  d0, d1, d2, d3, d4, d5;
    wire [5:0]  live, hl_gain, hr_gain;
    wire        hl_wait, hr_wait, hl_sil, hr_sil, hl_zc, hr_zc;
    wire        hl_on, hr_on, fb_en;
    int         n_mismatch = 0, check_count = 0;
    int         i;

    output_mixer_gain_headphone_volume_regs dut_u (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .left_zero_cross(left_zero_cross),
        .right_zero_cross(right_zero_cross),
        .lpre_to_lmix_gain(g0), .rpre_to_lmix_gain(g1),
        .laux_to_lmix_gain(g2), .lpre_to_rmix_gain(g3),
        .rpre_to_rmix_gain(g4), .raux_to_rmix_gain(g5),
        .lpre_to_lmix_db(d0), .rpre_to_lmix_db(d1), .laux_to_lmix_db(d2),
        .lpre_to_rmix_db(d3), .rpre_to_rmix_db(d4), .raux_to_rmix_db(d5),
        .mix_path_live(live), .hp_left_gain(hl_gain),
        .hp_right_gain(hr_gain), .hp_left_waiting(hl_wait),
        .hp_right_waiting(hr_wait), .hp_left_silence(hl_sil),
        .hp_right_silence(hr_sil), .hp_left_zero_cross(hl_zc),
        .hp_right_zero_cross(hr_zc), .hp_left_on(hl_on),
        .hp_right_on(hr_on), .hp_ground_feedback_en(fb_en));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ========================================================
    // Bus tasks: a gap edge between strobes avoids double drives
    task automatic wr(input [7:0] a, input [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input [7:0] a, input [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, exp)
    endtask

    task automatic zc_pulse(input bit right);
        @(posedge ref_clk);
        if (right) right_zero_cross <= 1'b1; else left_zero_cross <= 1'b1;
        @(posedge ref_clk);
        right_zero_cross <= 1'b0;
        left_zero_cross <= 1'b0;
        #1;
    endtask

    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic [4:0] db_of(input int c);
        // Signed dB in five bits; code 0 means the path is cut
        db_of = (c == 0) ? 5'h00 : 5'((3 * c) - 15);
    endfunction

    initial begin
        #(50 * 3000);
        n_mismatch++;
        end_of_test;
    end

    // ========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        `CHK(hl_gain, 6'h39)
        rd(8'h60, 16'h0000);
        rd(8'h61, 16'h0000);
        rd(8'h4C, 16'h0000);
        rd(8'h68, 16'h00E4);
        rd(8'h69, 16'h00E4);
        wr(8'h60, 16'hFFFF);
        rd(8'h60, 16'h0EEE);
        wr(8'h61, 16'hFFFF);
        rd(8'h61, 16'hE0EE);
        `CHK({g0, g1, g2, g3, g4, g5}, 18'h3FFFF)
        `CHK({d0, d1, d2, d3, d4, d5}, {6{5'h06}})
        `CHK(live, 6'h3F)
        wr(8'h4C, 16'hFFFF);
        `CHK(fb_en, 1'b1)
        rd(8'h4C, 16'h0001);
        wr(8'h62, 16'hFFFF);
        rd(8'h62, 16'h0000);
        for (i = 0; i < 8; i++) begin
            wr(8'h60, 16'(i << 1));
            @(posedge ref_clk);
            #1;
            `CHK(d0, db_of(i))
            `CHK(live[0], (i != 0))
        end
        wr(8'h68, 16'h0028);
        `CHK(hl_gain, 6'h39)
        rd(8'h68, 16'h0028);
        wr(8'h69, 16'h0150);
        `CHK({hl_gain, hr_gain}, 12'h294)
        rd(8'h69, 16'h0050);
        wr(8'h68, 16'hE180);
        `CHK({hl_wait, hl_gain}, 7'h4A)
        `CHK({hl_on, hl_sil, hl_zc}, 3'h7)
        rd(8'h0A, 16'h0001);
        zc_pulse(1'b0);
        `CHK({hl_wait, hl_gain}, 7'h20)
        wr(8'h0A, 16'h0002);
        `CHK({hl_on, hr_on}, 2'h1)
        rd(8'h68, 16'h6080);
        rd(8'h69, 16'h8050);
        wr(8'h69, 16'hA114);
        `CHK({hr_wait, hr_gain}, 7'h54)
        `CHK({hr_on, hr_sil, hr_zc}, 3'h5)
        zc_pulse(1'b1);
        `CHK({hr_wait, hr_gain}, 7'h05)
        // Left still armed; a plain commit releases it, right re-arms
        wr(8'h68, 16'h0104);
        `CHK({hl_wait, hl_gain}, 7'h01)
        `CHK({hr_wait, hr_gain}, 7'h45)
        end_of_test;
    end
endmodule

bind output_mixer_gain_headphone_volume_regs mixer_hp_checker chk_u (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .left_zero_cross(left_zero_cross),
    .lpre_to_lmix_gain(lpre_to_lmix_gain),
    .raux_to_rmix_gain(raux_to_rmix_gain),
    .lpre_to_lmix_db(lpre_to_lmix_db), .mix_path_live(mix_path_live),
    .hp_left_gain(hp_left_gain), .hp_left_waiting(hp_left_waiting),
    .hp_ground_feedback_en(hp_ground_feedback_en));
